//--- common/lmsp_params.svh
`ifndef LMSP_PARAMS_SVH
`define LMSP_PARAMS_SVH

`define LMSP_PAGE_PWM 2'h0
`define LMSP_PAGE_FUNC 2'h2
`define LMSP_PWM_FIRST 8'h01
`define LMSP_PWM_LAST 8'h90
`define LMSP_FN_CONFIG 8'h00
`define LMSP_FN_CURRENT 8'h01
`define LMSP_FN_FAULT_FIRST 8'h03
`define LMSP_FN_FAULT_LAST 8'h1A
`define LMSP_FN_THERMAL 8'h24
`define LMSP_FN_SYNC 8'h25
`define LMSP_FN_RESET 8'h2F
`define LMSP_RESET_KEY 8'hAE

`define LMSP_CFG_RESET 8'h00
`define LMSP_CURRENT_RESET 8'h00
`define LMSP_THERMAL_RESET 4'h0
`define LMSP_SYNC_RESET 8'h00

`define LMSP_CFG_SSD_BIT 0
`define LMSP_CFG_DETECT_LSB 1
`define LMSP_TH_LEVEL_LSB 0
`define LMSP_TH_POINT_LSB 2
`define LMSP_SS_PERIOD_LSB 0
`define LMSP_SS_RANGE_LSB 2
`define LMSP_SS_SPREAD_BIT 4
`define LMSP_SS_SYNC_LSB 6

`define LMSP_DETECT_OFF 2'h0
`define LMSP_DETECT_SHORT 2'h2
`define LMSP_SYNC_SLAVE 2'h2
`define LMSP_SYNC_MASTER 2'h3

`define LMSP_PCT_FULL 7'h64
`define LMSP_PCT_L1 7'h4B
`define LMSP_PCT_L2 7'h37
`define LMSP_PCT_L3 7'h1E

`define LMSP_CLK_NS 5
`define LMSP_TICK_CYC 2
`define LMSP_TICK_NS (`LMSP_CLK_NS * `LMSP_TICK_CYC)
`define LMSP_SLOT_NS 33000
`define LMSP_NOL1_NS 830
`define LMSP_NOL2_NS 300
`define LMSP_SLOT_TICKS ((`LMSP_SLOT_NS + `LMSP_TICK_NS - 1) / `LMSP_TICK_NS)
`define LMSP_NOL1_TICKS ((`LMSP_NOL1_NS + `LMSP_TICK_NS - 1) / `LMSP_TICK_NS)
`define LMSP_NOL2_TICKS ((`LMSP_NOL2_NS + `LMSP_TICK_NS - 1) / `LMSP_TICK_NS)

`define LMSP_ACC_ONE 17'h1_0000
`define LMSP_ACC_BASE (`LMSP_ACC_ONE / `LMSP_TICK_CYC)
`define LMSP_DEV_K(pct) (((`LMSP_ACC_BASE * (pct)) / 100) / 128)
`define LMSP_DEV_K0 `LMSP_DEV_K(5)
`define LMSP_DEV_K1 `LMSP_DEV_K(15)
`define LMSP_DEV_K2 `LMSP_DEV_K(24)
`define LMSP_DEV_K3 `LMSP_DEV_K(34)
`define LMSP_PERIOD_STEP(us) (((us) * 1000) / `LMSP_CLK_NS / 512)
`define LMSP_PERIOD_STEP0 `LMSP_PERIOD_STEP(1980)
`define LMSP_PERIOD_STEP1 `LMSP_PERIOD_STEP(1200)
`define LMSP_PERIOD_STEP2 `LMSP_PERIOD_STEP(820)
`define LMSP_PERIOD_STEP3 `LMSP_PERIOD_STEP(660)

`endif

//--- common/lmsp_pkg.sv
package lmsp_pkg;

  typedef enum logic [1:0] {
    LMSP_PH_ACTIVE = 2'b00,
    LMSP_PH_NOL1 = 2'b01,
    LMSP_PH_NOL2 = 2'b10
  } lmsp_phase_t;

  typedef struct packed {
    logic [15:0] acc;
    logic tick;
    logic [7:0] ph;
    logic dir_down;
    logic [9:0] div;
  } lmsp_timer_t;

  typedef struct packed {
    logic [143:0][7:0] duty;
    logic [7:0][17:0] fault;
    logic [7:0] cfg;
    logic [7:0] current_scale;
    logic [3:0] thermal;
    logic [7:0] sync_ss;
    lmsp_phase_t phase;
    logic [2:0] row;
    logic [11:0] pos;
    logic det_busy;
    logic det_started;
    logic det_short;
    logic sync_last;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] row_switch;
    logic [17:0] column_sink;
    logic sync_out;
    logic sync_oe;
    logic sync_pd_en;
    logic derate_active;
    logic [6:0] current_pct;
  } lmsp_core_t;

endpackage

//--- design/lmsp_scan_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "lmsp_params.svh"

module lmsp_scan_timer (
  input wire logic clock, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic spread_enable_bit, // dither on
  input wire logic [1:0] spread_range_select, // deviation select
  input wire logic [1:0] spread_period_select, // dither cycle select
  output logic tick // one scan time step
);

  lmsp_pkg::lmsp_timer_t s_q, s_d;
  logic [17:0] inc;
  logic [17:0] dev;
  logic [9:0] step_len;
  logic [17:0] sum;

  function automatic logic [7:0] dev_k(input logic [1:0] sel);
    case (sel)
      2'h0: dev_k = 8'(`LMSP_DEV_K0);
      2'h1: dev_k = 8'(`LMSP_DEV_K1);
      2'h2: dev_k = 8'(`LMSP_DEV_K2);
      default: dev_k = 8'(`LMSP_DEV_K3);
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    // triangle phase sweeps 0..255..0 once per selected cycle time
    case (spread_period_select)
      2'h0: step_len = 10'(`LMSP_PERIOD_STEP0);
      2'h1: step_len = 10'(`LMSP_PERIOD_STEP1);
      2'h2: step_len = 10'(`LMSP_PERIOD_STEP2);
      default: step_len = 10'(`LMSP_PERIOD_STEP3);
    endcase
    dev = 18'($signed({1'b0, s_q.ph}) - 10'sd128) * 18'(dev_k(spread_range_select));
    inc = spread_enable_bit ? 18'(`LMSP_ACC_BASE) + dev : 18'(`LMSP_ACC_BASE);
    if (s_q.div >= step_len - 10'h001) begin
      s_d.div = 10'h000;
      if (s_q.dir_down) begin
        s_d.ph = s_q.ph - 8'h01;
        if (s_q.ph == 8'h01) begin
          s_d.dir_down = 1'b0;
        end
      end else begin
        s_d.ph = s_q.ph + 8'h01;
        if (s_q.ph == 8'hFE) begin
          s_d.dir_down = 1'b1;
        end
      end
    end else begin
      s_d.div = s_q.div + 10'h001;
    end
    // carry out of the phase accumulator marks a tick; rate follows inc
    sum = {2'b00, s_q.acc} + inc;
    s_d.acc = sum[15:0];
    s_d.tick = sum[16];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule
`default_nettype wire

//--- design/lmsp_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "lmsp_params.svh"

module lmsp_core #(
  parameter int ROWS = 8,
  parameter int COLS = 18,
  parameter logic [11:0] SLOT_TICKS = 12'(`LMSP_SLOT_TICKS),
  parameter logic [11:0] NOL1_TICKS = 12'(`LMSP_NOL1_TICKS),
  parameter logic [11:0] NOL2_TICKS = 12'(`LMSP_NOL2_TICKS)
) (
  input wire logic clock, // system clock, 200 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [1:0] reg_page, // register page
  input wire logic [7:0] reg_addr, // register offset in page
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data
  output logic reg_rvalid, // read data valid pulse
  input wire logic [17:0] column_open_sense, // per column open comparator
  input wire logic [17:0] column_short_sense, // per column short comparator
  input wire logic [3:0] temp_above, // die above 140/120/100/90 C
  input wire logic sync_in, // sync pin input
  output logic sync_out, // sync pin output value
  output logic sync_oe, // sync pin output enable
  output logic sync_pd_en, // weak pull-down on sync pin
  output logic [7:0] row_switch, // row switch enables
  output logic [17:0] column_sink, // column sink enables
  output logic [7:0] global_current_scale, // global current code
  output logic derate_active, // thermal roll-off engaged
  output logic [6:0] current_pct // output current percentage
);

  lmsp_pkg::lmsp_core_t s_q, s_d;
  logic int_tick;
  logic tick;
  logic [1:0] detect_new;
  logic [1:0] sync_role;
  logic [7:0] fault_idx;
  logic [7:0] pwm_idx;
  logic slot_end;
  logic [19:0] pos_scaled;
  logic [17:0] sink_row;

  lmsp_scan_timer lmsp_scan_timer_inst (
    .clock(clock),
    .rst_b(rst_b),
    .spread_enable_bit(s_q.sync_ss[`LMSP_SS_SPREAD_BIT]),
    .spread_range_select(s_q.sync_ss[`LMSP_SS_RANGE_LSB +: 2]),
    .spread_period_select(s_q.sync_ss[`LMSP_SS_PERIOD_LSB +: 2]),
    .tick(int_tick)
  );

  // six column bits of one fault result byte, upper two read zero
  function automatic logic [7:0] fault_byte(input logic [7:0][17:0] f, input logic [7:0] idx);
    logic [2:0] r;
    logic [1:0] g;
    r = 3'(idx / 8'd3);
    g = 2'(idx % 8'd3);
    fault_byte = {2'b00, f[r][g*6 +: 6]};
  endfunction

  function automatic logic [6:0] rolloff_pct(input logic [1:0] lvl);
    case (lvl)
      2'h0: rolloff_pct = `LMSP_PCT_FULL;
      2'h1: rolloff_pct = `LMSP_PCT_L1;
      2'h2: rolloff_pct = `LMSP_PCT_L2;
      default: rolloff_pct = `LMSP_PCT_L3;
    endcase
  endfunction

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // per-column PWM compare for the lit row
  genvar gc;
  generate
    for (gc = 0; gc < COLS; gc++) begin : g_col
      logic [19:0] dprod;
      assign dprod = 20'(s_q.duty[s_q.row * COLS + gc]) * 20'(SLOT_TICKS);
      // on while pos/slot < duty/256; duty 0 never lights
      assign sink_row[gc] = pos_scaled < dprod;
    end
  endgenerate

  assign sync_role = s_q.sync_ss[`LMSP_SS_SYNC_LSB +: 2];
  assign pos_scaled = {s_q.pos, 8'h00};
  assign fault_idx = reg_addr - `LMSP_FN_FAULT_FIRST;
  assign pwm_idx = reg_addr - `LMSP_PWM_FIRST;
  assign detect_new = reg_wdata[`LMSP_CFG_DETECT_LSB +: 2];
  // slave steps on each edge of the master's clock, else on its own timer
  assign tick = (sync_role == `LMSP_SYNC_SLAVE) ? (sync_in != s_q.sync_last) : int_tick;
  assign slot_end = (s_q.phase == lmsp_pkg::LMSP_PH_ACTIVE) && (s_q.pos == SLOT_TICKS - 12'h001);

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.sync_last = sync_in;

    // scan sequencer: active slot, non-overlap gap, column delay
    if (tick) begin
      case (s_q.phase)
        lmsp_pkg::LMSP_PH_ACTIVE: begin
          if (slot_end) begin
            s_d.phase = lmsp_pkg::LMSP_PH_NOL1;
            s_d.pos = 12'h000;
          end else begin
            s_d.pos = s_q.pos + 12'h001;
          end
        end
        lmsp_pkg::LMSP_PH_NOL1: begin
          if (s_q.pos == NOL1_TICKS - 12'h001) begin
            s_d.phase = lmsp_pkg::LMSP_PH_NOL2;
            s_d.pos = 12'h000;
          end else begin
            s_d.pos = s_q.pos + 12'h001;
          end
        end
        lmsp_pkg::LMSP_PH_NOL2: begin
          if (s_q.pos == NOL2_TICKS - 12'h001) begin
            s_d.phase = lmsp_pkg::LMSP_PH_ACTIVE;
            s_d.pos = 12'h000;
            s_d.row = s_q.row + 3'h1;
          end else begin
            s_d.pos = s_q.pos + 12'h001;
          end
        end
        default: begin
          s_d.phase = lmsp_pkg::LMSP_PH_ACTIVE;
          s_d.pos = 12'h000;
        end
      endcase
    end

    // fault check: arms on trigger, spans one full frame from row 0
    if (s_q.det_busy && tick && s_q.phase == lmsp_pkg::LMSP_PH_ACTIVE
        && s_q.pos == 12'h000 && s_q.row == 3'h0) begin
      s_d.det_started = 1'b1;
    end
    if (s_q.det_busy && s_q.det_started && tick && slot_end) begin
      // results only move while a triggered check is running, or clear on the reset key write
      s_d.fault[s_q.row] = s_q.det_short ? column_short_sense : column_open_sense;
      if (s_q.row == 3'(ROWS - 1)) begin
        s_d.det_busy = 1'b0;
        s_d.det_started = 1'b0;
      end
    end

    // register writes; duty lands in the live array the scan reads
    if (reg_wr) begin
      if (reg_page == `LMSP_PAGE_PWM && in_range(reg_addr, `LMSP_PWM_FIRST, `LMSP_PWM_LAST)) begin
        s_d.duty[pwm_idx] = reg_wdata;
      end
      if (reg_page == `LMSP_PAGE_FUNC) begin
        case (reg_addr)
          `LMSP_FN_CONFIG: begin
            s_d.cfg = reg_wdata;
            // a check fires only on leaving 00, so changing one nonzero code to another starts no check
            if (s_q.cfg[`LMSP_CFG_DETECT_LSB +: 2] == `LMSP_DETECT_OFF
                && detect_new != `LMSP_DETECT_OFF) begin
              s_d.det_busy = 1'b1;
              s_d.det_started = 1'b0;
              s_d.det_short = (detect_new == `LMSP_DETECT_SHORT);
            end
          end
          `LMSP_FN_CURRENT: begin
            s_d.current_scale = reg_wdata;
          end
          `LMSP_FN_THERMAL: begin
            s_d.thermal = reg_wdata[3:0];
          end
          `LMSP_FN_SYNC: begin
            s_d.sync_ss = reg_wdata;
          end
          `LMSP_FN_RESET: begin
            if (reg_wdata == `LMSP_RESET_KEY) begin
              s_d.duty = '0;
              s_d.fault = '0;
              s_d.cfg = `LMSP_CFG_RESET;
              s_d.current_scale = `LMSP_CURRENT_RESET;
              s_d.thermal = `LMSP_THERMAL_RESET;
              s_d.sync_ss = `LMSP_SYNC_RESET;
              s_d.det_busy = 1'b0;
              s_d.det_started = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // register reads answer one cycle later; unmapped reads give zero
    if (reg_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = 8'h00;
      if (reg_page == `LMSP_PAGE_PWM && in_range(reg_addr, `LMSP_PWM_FIRST, `LMSP_PWM_LAST)) begin
        s_d.rdata = s_q.duty[pwm_idx];
      end
      if (reg_page == `LMSP_PAGE_FUNC) begin
        case (reg_addr)
          `LMSP_FN_CONFIG: s_d.rdata = s_q.cfg;
          `LMSP_FN_CURRENT: s_d.rdata = s_q.current_scale;
          `LMSP_FN_THERMAL: s_d.rdata = {4'h0, s_q.thermal};
          `LMSP_FN_SYNC: s_d.rdata = s_q.sync_ss;
          default: begin
            if (in_range(reg_addr, `LMSP_FN_FAULT_FIRST, `LMSP_FN_FAULT_LAST)) begin
              s_d.rdata = fault_byte(s_q.fault, fault_idx);
            end
          end
        endcase
      end
    end

    // row and column drive; shutdown bit blanks everything
    s_d.row_switch = 8'h00;
    s_d.column_sink = 18'h0_0000;
    if (s_q.cfg[`LMSP_CFG_SSD_BIT] && s_q.phase == lmsp_pkg::LMSP_PH_ACTIVE) begin
      s_d.row_switch[s_q.row] = 1'b1;
      s_d.column_sink = sink_row;
    end

    // sync pin
    case (sync_role)
      `LMSP_SYNC_MASTER: begin
        s_d.sync_oe = 1'b1;
        s_d.sync_pd_en = 1'b0;
        if (int_tick) begin
          s_d.sync_out = ~s_q.sync_out;
        end
      end
      `LMSP_SYNC_SLAVE: begin
        s_d.sync_oe = 1'b0;
        s_d.sync_pd_en = 1'b0;
        s_d.sync_out = 1'b0;
      end
      default: begin
        s_d.sync_oe = 1'b0;
        s_d.sync_pd_en = 1'b1;
        s_d.sync_out = 1'b0;
      end
    endcase

    // thermal roll-off
    s_d.derate_active = temp_above[s_q.thermal[`LMSP_TH_POINT_LSB +: 2]];
    s_d.current_pct = s_d.derate_active ?
                      rolloff_pct(s_q.thermal[`LMSP_TH_LEVEL_LSB +: 2]) : `LMSP_PCT_FULL;
  end

  // reset loads every default: shutdown, zero duty, blank rows
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.current_pct <= `LMSP_PCT_FULL;
      s_q.sync_pd_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign sync_out = s_q.sync_out;
  assign sync_oe = s_q.sync_oe;
  assign sync_pd_en = s_q.sync_pd_en;
  assign row_switch = s_q.row_switch;
  assign column_sink = s_q.column_sink;
  assign global_current_scale = s_q.current_scale;
  assign derate_active = s_q.derate_active;
  assign current_pct = s_q.current_pct;

endmodule
`default_nettype wire

//--- tb/lmsp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lmsp_properties (
  input wire logic clock, // clock
  input wire logic rst_b, // reset
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [1:0] reg_page, // page
  input wire logic [7:0] reg_addr, // offset
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic [7:0] reg_rdata, // rdata
  input wire logic reg_rvalid, // rvalid
  input wire logic sync_oe, // sync drive
  input wire logic sync_pd_en, // pull-down
  input wire logic [7:0] row_switch, // rows
  input wire logic [17:0] column_sink, // columns
  input wire logic [7:0] global_current_scale, // current scale
  input wire logic derate_active, // derating
  input wire logic [6:0] current_pct // percent
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence key_write;
    reg_wr && reg_page == 2'h2 && reg_addr == 8'h2f && reg_wdata == 8'hae;
  endsequence
  sequence all_blank;
    global_current_scale == 8'h00 ##1 row_switch == 8'h00 && column_sink == 18'h0_0000;
  endsequence

  rows_onehot_a: assert property ($onehot0(row_switch))
    else $error("two rows lit");
  row_release_a: assert property (
    $past(row_switch) != 8'h00 && $changed(row_switch) |-> row_switch == 8'h00)
    else $error("row handover without gap");
  row_gap_a: assert property ($fell(|row_switch) |=> (row_switch == 8'h00)[*4])
    else $error("row gap too short");
  cols_in_slot_a: assert property (column_sink != 18'h0_0000 |-> row_switch != 8'h00)
    else $error("column on outside slot");
  read_answer_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer late");
  fault_upper_zero_a: assert property (reg_rd && reg_page == 2'h2 &&
    reg_addr inside {[8'h03:8'h1a]} |=> reg_rdata[7:6] == 2'b00)
    else $error("fault byte upper bits set");
  derate_pct_a: assert property (!derate_active |-> current_pct == 7'h64)
    else $error("current cut without derating");
  pct_levels_a: assert property (current_pct inside {7'h64, 7'h4b, 7'h37, 7'h1e})
    else $error("current level off table");
  master_drive_a: assert property (sync_oe |-> !sync_pd_en)
    else $error("pull-down on while driving");
  soft_reset_a: assert property (key_write |=> all_blank)
    else $error("reset key left state");
endmodule

bind lmsp_core lmsp_properties lmsp_properties_inst (.clock(clock), .rst_b(rst_b),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_page(reg_page), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .sync_oe(sync_oe), .sync_pd_en(sync_pd_en), .row_switch(row_switch),
  .column_sink(column_sink), .global_current_scale(global_current_scale),
  .derate_active(derate_active), .current_pct(current_pct));
`default_nettype wire

//--- tb/lmsp_matrix_model.sv
`timescale 1ns/1ps
`default_nettype none
module lmsp_matrix_model (
  input wire logic [7:0] row_switch, // lit row
  output logic [17:0] column_open_sense, // open per column
  output logic [17:0] column_short_sense // short per column
);
  initial begin
    column_open_sense = 18'h0_0000;
    column_short_sense = 18'h3_ffff;
  end

  // between rows nothing valid is sensed, so the last value is flipped
  always @(row_switch) begin
    column_open_sense = ~column_open_sense;
    for (int r = 0; r < 8; r++) begin
      if (row_switch[r]) begin
        column_open_sense = 18'h2_5a3c ^ (18'(r) * 18'h0_4925);
      end
    end
    column_short_sense = ~column_open_sense;
  end
endmodule
`default_nettype wire

//--- tb/lmsp_core_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "lmsp_params.svh"
module lmsp_core_test;
  localparam logic [1:0] FN = `LMSP_PAGE_FUNC;
  localparam int SLOT = 20;
  localparam int GAP = 5;
  localparam int WAIT = 16 * (SLOT + GAP) * 2 + 50;
  logic clock, rst_b, reg_wr, reg_rd, reg_rvalid, sync_drv, sync_out, sync_oe;
  logic sync_pd_en, derate_active;
  logic [1:0] reg_page;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, row_switch, global_current_scale, v;
  logic [3:0] temp_above;
  logic [17:0] open_s, short_s, column_sink;
  logic [6:0] current_pct;
  logic [6:0] pct [4] = '{7'h64, 7'h4b, 7'h37, 7'h1e};
  int n_errors, checked, n;
  wire sync_in;

  // sync pin level: design drives, else pull-down, else the bench
  assign sync_in = sync_oe ? sync_out : (sync_pd_en ? 1'b0 : sync_drv);

  lmsp_core #(.SLOT_TICKS(12'h014), .NOL1_TICKS(12'h003), .NOL2_TICKS(12'h002)) lmsp_core_inst (
    .clock(clock), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .column_open_sense(open_s), .column_short_sense(short_s), .temp_above(temp_above),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe), .sync_pd_en(sync_pd_en),
    .row_switch(row_switch), .column_sink(column_sink),
    .global_current_scale(global_current_scale), .derate_active(derate_active),
    .current_pct(current_pct));
  lmsp_matrix_model lmsp_matrix_model_inst (.row_switch(row_switch),
    .column_open_sense(open_s), .column_short_sense(short_s));

  task automatic tk(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // strobes drop for one edge between accesses so no signal is set twice at once
  task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
    reg_page = p;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tk(1);
    reg_wr = 1'b0;
    tk(1);
  endtask
  task automatic rchk(input logic [1:0] p, input logic [7:0] a, input logic [7:0] e);
    reg_page = p;
    reg_addr = a;
    reg_rd = 1'b1;
    tk(1);
    reg_rd = 1'b0;
    check(reg_rvalid, 1'b1);
    check(reg_rdata, e);
    tk(1);
  endtask
  task automatic fchk(input logic inv);
    logic [17:0] p;
    for (int r = 0; r < 8; r++) begin
      p = (18'h2_5a3c ^ (18'(r) * 18'h0_4925)) ^ {18{inv}};
      for (int g = 0; g < 3; g++) rchk(FN, 8'(3 + 3 * r + g), {2'b00, p[6 * g +: 6]});
    end
  endtask
  // measures row 2, column 5 over one slot and the gap after it
  task automatic slot(input logic [7:0] d);
    int nr, nc, ng;
    nr = 0;
    nc = 0;
    ng = 0;
    wr(2'h0, 8'h2a, d);
    while (row_switch == 8'h04) tk(1);
    while (row_switch != 8'h04) tk(1);
    while (row_switch == 8'h04) begin
      nr++;
      nc += column_sink[5];
      tk(1);
    end
    while (row_switch == 8'h00) begin
      ng++;
      tk(1);
    end
    check(nr, SLOT * 2);
    check(nc, ((d * SLOT + 255) / 256) * 2);
    check(ng, GAP * 2);
    check(row_switch, 8'h08);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #200000;
    n_errors++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_page = 2'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    temp_above = 4'h0;
    sync_drv = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (16) @(posedge clock);
    #1;
    rst_b = 1'b1;
    check(sync_pd_en, 1'b1);
    check(current_pct, 7'h64);
    check(row_switch, 8'h00);
    check(column_sink, 18'h0_0000);
    rchk(FN, 8'h00, 8'h00);
    rchk(FN, 8'h01, 8'h00);
    rchk(FN, 8'h24, 8'h00);
    rchk(FN, 8'h25, 8'h00);
    for (int a = 3; a <= 26; a++) rchk(FN, 8'(a), 8'h00);
    wr(FN, 8'h03, 8'hff);
    rchk(FN, 8'h03, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(FN, 8'h24, 8'(i) | 8'hf0);
      rchk(FN, 8'h24, 8'(i));
      temp_above = 4'h1 << (i / 4);
      tk(1);
      check(derate_active, 1'b1);
      check(current_pct, pct[i % 4]);
      temp_above = ~(4'h1 << (i / 4));
      tk(1);
      check(derate_active, 1'b0);
      check(current_pct, 7'h64);
    end
    wr(FN, 8'h00, 8'h01);
    slot(8'h00);
    slot(8'h01);
    slot(8'h80);
    slot(8'hff);
    wr(FN, 8'h01, 8'h01);
    check(global_current_scale, 8'h01);
    wr(FN, 8'h00, 8'h03);
    tk(WAIT);
    fchk(1'b0);
    wr(FN, 8'h00, 8'h01);
    wr(FN, 8'h00, 8'h05);
    tk(WAIT);
    fchk(1'b1);
    wr(FN, 8'h00, 8'h07);
    tk(WAIT);
    fchk(1'b1);
    wr(FN, 8'h00, 8'h01);
    wr(FN, 8'h00, 8'h07);
    tk(WAIT);
    fchk(1'b0);
    wr(FN, 8'h25, 8'hc0);
    check(sync_oe, 1'b1);
    check(sync_pd_en, 1'b0);
    n = 0;
    repeat (20) begin
      v[0] = sync_out;
      tk(1);
      n += (sync_out != v[0]);
    end
    check(n, 10);
    wr(FN, 8'h25, 8'h80);
    check(sync_oe, 1'b0);
    check(sync_pd_en, 1'b0);
    tk(4);
    v = row_switch;
    tk(200);
    check(row_switch, v);
    n = 0;
    repeat (60) begin
      sync_drv = ~sync_drv;
      tk(1);
      n += (row_switch != v);
    end
    check(n > 0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      wr(FN, 8'h25, 8'(i) << 6);
      check(sync_pd_en, 1'b1);
      check(sync_oe, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(FN, 8'h25, 8'h10 | 8'(i * 5));
      rchk(FN, 8'h25, 8'h10 | 8'(i * 5));
    end
    // dither phase sits near its low end this early, so the tick rate drops about a third
    wr(FN, 8'h25, 8'hdf);
    n = 0;
    repeat (200) begin
      v[0] = sync_out;
      tk(1);
      n += (sync_out != v[0]);
    end
    check(n >= 65 && n < 100, 1'b1);
    wr(FN, 8'h01, 8'h40);
    wr(FN, 8'h2f, 8'h55);
    check(global_current_scale, 8'h40);
    wr(FN, 8'h2f, 8'hae);
    check(global_current_scale, 8'h00);
    rchk(FN, 8'h00, 8'h00);
    rchk(FN, 8'h25, 8'h00);
    rchk(FN, 8'h03, 8'h00);
    rchk(2'h0, 8'h2a, 8'h00);
    results();
  end
endmodule
`default_nettype wire
